// *** logic/arsr_device.sv ***
// Device end of the converter readout: conversion timing and the serial output word.
// Assumes the host drives sclk and the control pins asynchronously to pclk.
//
// Contract
// - Link is shift clock plus shared line.
// - Line low when fresh word available.
// - Shift 32 bits: result then status.
// - Line high after word fully read.
// - Unread word withdrawn shortly before update.
// - Each conversion readable only once.
// - Every conversion reloads, abandoning partial shift.
// - Host finishes read before next conversion.
// - Line floats while sleep/reset low.
// - Wait oscillator start, then convert continuously.
// - First conversion after full filter settling.
// - Line high on wake until conversion.
// - Later conversions at selected update rate.
// - Filter/gain change restarts conversion, line high.
// - Line high until new settling elapses.
// - Host finishes read before changing pins.
// - Range error bit set on bad input.
// - Status carries two-bit part code.
// - Check pattern 01 marks good transfer.
// - Filter low 16.7 Hz, high 10 Hz.
// - Gain low 128, high unity.
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module arsr_device #(
  parameter int unsigned WAKE_CYC     = arsr_pkg::WAKE_CYC,
  parameter int unsigned PER_FAST_CYC = arsr_pkg::PER_FAST_CYC,
  parameter int unsigned PER_SLOW_CYC = arsr_pkg::PER_SLOW_CYC,
  parameter logic [1:0]  PART_CODE    = arsr_pkg::PART_CODE_DEF
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Link
  arsr_if.device           lnk,
  // Converter core
  input  wire logic [23:0] sample_data,
  input  wire logic        sample_range_err,
  output logic             conv_done
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned PIN_SCLK = 0;
  localparam int unsigned PIN_WAKE = 1;
  localparam int unsigned PIN_FILT = 2;
  localparam int unsigned PIN_GAIN = 3;

  wire  [3:0] pin_raw;
  logic [3:0] meta_ff;
  logic [3:0] sync_ff;
  logic [3:0] prev_ff;

  assign pin_raw = {lnk.gain_sel, lnk.filter_sel, lnk.sleep_reset_n, lnk.sclk};

  generate
    for (genvar i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_ff[i] <= arsr_pkg::PIN_IDLE[i];
          sync_ff[i] <= arsr_pkg::PIN_IDLE[i];
          prev_ff[i] <= arsr_pkg::PIN_IDLE[i];
        end else begin
          meta_ff[i] <= pin_raw[i];
          sync_ff[i] <= meta_ff[i];
          prev_ff[i] <= sync_ff[i];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  arsr_pkg::arsr_dev_state_t state_ff;
  arsr_pkg::arsr_dev_state_t nxt_state;
  arsr_pkg::arsr_cnt_t       cnt_ff;
  arsr_pkg::arsr_cnt_t       nxt_cnt;
  logic [1:0]                settle_ff;
  logic [1:0]                nxt_settle;
  logic [31:0]               sh_ff;
  logic [31:0]               nxt_sh;
  logic [4:0]                bits_ff;
  logic [4:0]                nxt_bits;
  logic                      avail_ff;
  logic                      nxt_avail;
  logic                      started_ff;
  logic                      nxt_started;
  logic                      done_ff;
  logic                      nxt_done;
  logic                      line_ff;
  logic                      oe_n_ff;

  wire awake     = sync_ff[PIN_WAKE];
  wire filt_slow = sync_ff[PIN_FILT];
  wire gain_one  = sync_ff[PIN_GAIN];
  wire sclk_fall = prev_ff[PIN_SCLK] & ~sync_ff[PIN_SCLK];
  wire sclk_rise = ~prev_ff[PIN_SCLK] & sync_ff[PIN_SCLK];
  wire cfg_chg   = (sync_ff[PIN_FILT] ^ prev_ff[PIN_FILT]) | (sync_ff[PIN_GAIN] ^ prev_ff[PIN_GAIN]);

  wire arsr_pkg::arsr_cnt_t per_last = filt_slow ? arsr_pkg::arsr_cnt_t'(PER_SLOW_CYC - 1)
                                                 : arsr_pkg::arsr_cnt_t'(PER_FAST_CYC - 1);
  wire arsr_pkg::arsr_cnt_t lead_at  = per_last - arsr_pkg::arsr_cnt_t'(arsr_pkg::LEAD_CYC);
  wire [1:0] settle_last = filt_slow ? 2'(arsr_pkg::SETTLE_SLOW_CONV - 1)
                                     : 2'(arsr_pkg::SETTLE_FAST_CONV - 1);
  wire per_end   = (cnt_ff == per_last);
  wire wake_end  = (cnt_ff == arsr_pkg::arsr_cnt_t'(WAKE_CYC - 1));
  wire in_lead   = (cnt_ff >= lead_at) & ~per_end;

  wire [7:0] status_byte = {
    1'b0,
    filt_slow,
    sample_range_err,
    PART_CODE,
    gain_one,
    arsr_pkg::CHECK_GOOD
  };
  wire [31:0] load_word = {sample_data, status_byte};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff + arsr_pkg::arsr_cnt_t'(1);
    nxt_settle  = settle_ff;
    nxt_sh      = sh_ff;
    nxt_bits    = bits_ff;
    nxt_avail   = avail_ff;
    nxt_started = started_ff;
    nxt_done    = 1'b0;

    // Shifting first, so that any reload below overrides a half-read word.
    if (avail_ff && sclk_fall) begin
      if (started_ff) begin
        nxt_sh = {sh_ff[30:0], 1'b1};
      end else begin
        nxt_started = 1'b1;
      end
    end
    if (avail_ff && started_ff && sclk_rise) begin
      nxt_bits = bits_ff + 5'h1;
      if (bits_ff == 5'h1f) begin
        nxt_avail   = 1'b0;
        nxt_started = 1'b0;
      end
    end
    if (avail_ff && in_lead) begin
      nxt_avail   = 1'b0;
      nxt_started = 1'b0;
    end

    case (state_ff)
      arsr_pkg::DEV_OFF: begin
        nxt_cnt = '0;
        if (awake) begin
          nxt_state = arsr_pkg::DEV_WAKE;
        end
      end
      arsr_pkg::DEV_WAKE: begin
        if (wake_end) begin
          nxt_state  = arsr_pkg::DEV_SETTLE;
          nxt_cnt    = '0;
          nxt_settle = 2'h0;
        end
      end
      arsr_pkg::DEV_SETTLE, arsr_pkg::DEV_RUN: begin
        if (per_end) begin
          nxt_cnt = '0;
          if (state_ff == arsr_pkg::DEV_SETTLE && settle_ff != settle_last) begin
            nxt_settle = settle_ff + 2'h1;
          end else begin
            nxt_state   = arsr_pkg::DEV_RUN;
            nxt_sh      = load_word;
            nxt_bits    = 5'h0;
            nxt_avail   = 1'b1;
            nxt_started = 1'b0;
            nxt_done    = 1'b1;
          end
        end
      end
      default: begin
        nxt_state = arsr_pkg::DEV_OFF;
      end
    endcase

    // A filter or gain pin change restarts settling from scratch and hides any word.
    if ((state_ff == arsr_pkg::DEV_SETTLE || state_ff == arsr_pkg::DEV_RUN) && cfg_chg) begin
      nxt_state   = arsr_pkg::DEV_SETTLE;
      nxt_cnt     = '0;
      nxt_settle  = 2'h0;
      nxt_avail   = 1'b0;
      nxt_started = 1'b0;
      nxt_done    = 1'b0;
    end
    if (!awake) begin
      nxt_state   = arsr_pkg::DEV_OFF;
      nxt_cnt     = '0;
      nxt_avail   = 1'b0;
      nxt_started = 1'b0;
      nxt_done    = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff   <= arsr_pkg::DEV_OFF;
      cnt_ff     <= '0;
      settle_ff  <= 2'h0;
      sh_ff      <= 32'h0;
      bits_ff    <= 5'h0;
      avail_ff   <= 1'b0;
      started_ff <= 1'b0;
      done_ff    <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      settle_ff  <= nxt_settle;
      sh_ff      <= nxt_sh;
      bits_ff    <= nxt_bits;
      avail_ff   <= nxt_avail;
      started_ff <= nxt_started;
      done_ff    <= nxt_done;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Registered from the next-state values so the pad never sees decode glitches, with no added pclk of latency.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_ff <= 1'b1;
      oe_n_ff <= 1'b1;
    end else begin
      line_ff <= ~nxt_avail | (nxt_started & nxt_sh[31]);
      oe_n_ff <= (nxt_state == arsr_pkg::DEV_OFF);
    end
  end

  assign lnk.dout_o    = line_ff;
  assign lnk.dout_oe_n = oe_n_ff;
  assign conv_done     = done_ff;

endmodule

// *** common/arsr_pkg.sv ***
// Shared constants and types for the converter readout link, device and host ends.
// Assumes both ends run on the same 200 MHz pclk.
package arsr_pkg;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int unsigned WORD_BITS   = 32;
  localparam int unsigned RESULT_BITS = 24;
  localparam int unsigned ST_RDY      = 7;
  localparam int unsigned ST_FILT     = 6;
  localparam int unsigned ST_ERR      = 5;
  localparam int unsigned ST_PART_HI  = 4;
  localparam int unsigned ST_PART_LO  = 3;
  localparam int unsigned ST_GAIN     = 2;
  localparam int unsigned ST_CHK_HI   = 1;
  localparam int unsigned ST_CHK_LO   = 0;
  localparam logic [1:0]  CHECK_GOOD  = 2'h1;
  // Part code value is arbitrary.
  localparam logic [1:0]  PART_CODE_DEF = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint PCLK_PERIOD_PS   = 5000;
  localparam longint WAKE_TIME_MS     = 1;
  localparam longint SETTLE_FAST_MS   = 120;
  localparam longint SETTLE_SLOW_MS   = 300;
  localparam int unsigned SETTLE_FAST_CONV = 2;
  localparam int unsigned SETTLE_SLOW_CONV = 3;
  localparam longint LEAD_TIME_NS     = 1000;
  localparam longint SCLK_HALF_NS     = 60;
  localparam int unsigned WAKE_CYC     = int'((WAKE_TIME_MS * 1000000000 + PCLK_PERIOD_PS - 1) / PCLK_PERIOD_PS);
  localparam int unsigned PER_FAST_CYC = int'(SETTLE_FAST_MS * 1000000000 / PCLK_PERIOD_PS / SETTLE_FAST_CONV);
  localparam int unsigned PER_SLOW_CYC = int'(SETTLE_SLOW_MS * 1000000000 / PCLK_PERIOD_PS / SETTLE_SLOW_CONV);
  localparam int unsigned LEAD_CYC     = int'((LEAD_TIME_NS * 1000 + PCLK_PERIOD_PS - 1) / PCLK_PERIOD_PS);
  localparam int unsigned SCLK_HALF_CYC = int'((SCLK_HALF_NS * 1000 + PCLK_PERIOD_PS - 1) / PCLK_PERIOD_PS);
  localparam int unsigned CNT_W = 25;
  typedef logic [CNT_W-1:0] arsr_cnt_t;
  // Synchroniser reset levels match each pin's idle level, so no false edge follows reset.
  localparam logic [3:0]  PIN_IDLE = 4'h1;

  // ----------------------------------------------------------------
  // Host registers
  // ----------------------------------------------------------------
  localparam logic [11:0] REG_CTRL  = 12'h000;
  localparam logic [11:0] REG_STAT  = 12'h004;
  localparam logic [11:0] REG_WORD  = 12'h008;
  localparam int unsigned CTRL_WAKE = 0;
  localparam int unsigned CTRL_FILT = 1;
  localparam int unsigned CTRL_GAIN = 2;
  localparam logic [2:0]  CTRL_RST  = 3'h0;
  localparam int unsigned STAT_NEW  = 0;
  localparam int unsigned STAT_CERR = 1;
  localparam int unsigned STAT_BUSY = 2;
  localparam int unsigned STAT_LOW  = 3;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DEV_OFF    = 2'h0,
    DEV_WAKE   = 2'h1,
    DEV_SETTLE = 2'h3,
    DEV_RUN    = 2'h2
  } arsr_dev_state_t;

  typedef enum logic [1:0] {
    HST_IDLE  = 2'h0,
    HST_SHIFT = 2'h1,
    HST_WAIT  = 2'h3
  } arsr_host_state_t;

endpackage

// *** common/arsr_if.sv ***
// Pin-level link between the converter readout device and its host.
// Assumes a pull-up on the shared data/ready line while the device floats it.
`timescale 1ns/100ps
interface arsr_if;
  logic sclk;
  logic sleep_reset_n;
  logic filter_sel;
  logic gain_sel;
  logic dout_o;
  logic dout_oe_n;
  logic line;
  logic line_z;

  assign line   = dout_oe_n ? 1'b1 : dout_o;
  assign line_z = dout_oe_n;

  modport device (
    input  sclk,
    input  sleep_reset_n,
    input  filter_sel,
    input  gain_sel,
    output dout_o,
    output dout_oe_n
  );

  modport host (
    output sclk,
    output sleep_reset_n,
    output filter_sel,
    output gain_sel,
    input  line
  );
endinterface

// *** logic/arsr_host.sv ***
// Host end of the converter readout: drives sclk and pins, reads words, APB slave.
// Assumes APB master on pclk; the data/ready line arrives asynchronously.
`timescale 1ns/100ps
module arsr_host (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Link
  arsr_if.host             lnk
);

  // ----------------------------------------------------------------
  // Line synchroniser
  // ----------------------------------------------------------------
  logic line_meta_ff;
  logic line_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_meta_ff <= 1'b1;
      line_ff      <= 1'b1;
    end else begin
      line_meta_ff <= lnk.line;
      line_ff      <= line_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [2:0]  ctrl_ff;
  logic [2:0]  pins_ff;
  logic [31:0] word_ff;
  logic        new_ff;
  logic        cerr_ff;
  logic [31:0] rdata_ff;
  arsr_pkg::arsr_host_state_t state_ff;

  wire hit_ctrl = (paddr == arsr_pkg::REG_CTRL);
  wire hit_stat = (paddr == arsr_pkg::REG_STAT);
  wire hit_word = (paddr == arsr_pkg::REG_WORD);
  wire mapped   = hit_ctrl | hit_stat | hit_word;
  wire setup    = psel & ~penable;
  wire wr_ok    = psel & penable & pwrite & mapped;
  wire stat_w1c_new  = wr_ok & hit_stat & pwdata[arsr_pkg::STAT_NEW];
  wire stat_w1c_cerr = wr_ok & hit_stat & pwdata[arsr_pkg::STAT_CERR];
  wire busy     = (state_ff != arsr_pkg::HST_IDLE);
  wire [31:0] stat_val = {28'h0, ~line_ff, busy, cerr_ff, new_ff};
  wire [31:0] rd_mux = hit_ctrl ? {29'h0, ctrl_ff} :
                       hit_stat ? stat_val :
                       hit_word ? word_ff : 32'h0;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = rdata_ff;

  // ----------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------
  arsr_pkg::arsr_host_state_t nxt_state;
  logic [4:0]  div_ff;
  logic [4:0]  nxt_div;
  logic        sclk_ff;
  logic        nxt_sclk;
  logic [4:0]  bits_ff;
  logic [4:0]  nxt_bits;
  logic [31:0] sh_ff;
  logic [31:0] nxt_sh;
  logic        fin;

  wire half_end = (div_ff == 5'(arsr_pkg::SCLK_HALF_CYC - 1));
  wire [31:0] got_word = {sh_ff[30:0], line_ff};
  wire got_bad = (got_word[arsr_pkg::ST_CHK_HI:arsr_pkg::ST_CHK_LO] != arsr_pkg::CHECK_GOOD);

  always_comb begin
    nxt_state = state_ff;
    nxt_div   = 5'h0;
    nxt_sclk  = sclk_ff;
    nxt_bits  = bits_ff;
    nxt_sh    = sh_ff;
    fin       = 1'b0;
    case (state_ff)
      arsr_pkg::HST_IDLE: begin
        nxt_sclk = 1'b1;
        nxt_bits = 5'h0;
        // Ready is only trusted once the device is awake and pins are settled.
        if (!line_ff && pins_ff[arsr_pkg::CTRL_WAKE] && pins_ff == ctrl_ff) begin
          nxt_state = arsr_pkg::HST_SHIFT;
        end
      end
      arsr_pkg::HST_SHIFT: begin
        nxt_div = div_ff + 5'h1;
        if (half_end) begin
          nxt_div  = 5'h0;
          nxt_sclk = ~sclk_ff;
          if (!sclk_ff) begin
            nxt_sh   = got_word;
            nxt_bits = bits_ff + 5'h1;
            if (bits_ff == 5'h1f) begin
              nxt_state = arsr_pkg::HST_WAIT;
              fin       = 1'b1;
            end
          end
        end
      end
      arsr_pkg::HST_WAIT: begin
        if (line_ff) begin
          nxt_state = arsr_pkg::HST_IDLE;
        end
      end
      default: begin
        nxt_state = arsr_pkg::HST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= arsr_pkg::HST_IDLE;
      div_ff   <= 5'h0;
      sclk_ff  <= 1'b1;
      bits_ff  <= 5'h0;
      sh_ff    <= 32'h0;
    end else begin
      state_ff <= nxt_state;
      div_ff   <= nxt_div;
      sclk_ff  <= nxt_sclk;
      bits_ff  <= nxt_bits;
      sh_ff    <= nxt_sh;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Pins follow the control register only between reads.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff  <= arsr_pkg::CTRL_RST;
      pins_ff  <= arsr_pkg::CTRL_RST;
      word_ff  <= 32'h0;
      new_ff   <= 1'b0;
      cerr_ff  <= 1'b0;
      rdata_ff <= 32'h0;
    end else begin
      if (wr_ok && hit_ctrl) begin
        ctrl_ff <= pwdata[2:0];
      end
      if (state_ff == arsr_pkg::HST_IDLE) begin
        pins_ff <= ctrl_ff;
      end
      if (fin) begin
        word_ff <= got_word;
      end
      // Set wins over a same-cycle clear.
      new_ff  <= fin | (new_ff & ~stat_w1c_new);
      cerr_ff <= (fin & got_bad) | (cerr_ff & ~stat_w1c_cerr);
      if (setup) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  assign lnk.sclk          = sclk_ff;
  assign lnk.sleep_reset_n = pins_ff[arsr_pkg::CTRL_WAKE];
  assign lnk.filter_sel    = pins_ff[arsr_pkg::CTRL_FILT];
  assign lnk.gain_sel      = pins_ff[arsr_pkg::CTRL_GAIN];

endmodule

// *** tb/arsr_asserts.sv ***
// Concurrent checks on the readout link pins between the device and host ends.
// Assumes the bench instantiates it beside the link interface, on the same pclk.
`timescale 1ns/100ps
module arsr_asserts #(
  parameter int unsigned WAKE_CYC     = arsr_pkg::WAKE_CYC,
  parameter int unsigned PER_FAST_CYC = arsr_pkg::PER_FAST_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link pins
  input wire logic sclk,
  input wire logic sleep_reset_n,
  input wire logic filter_sel,
  input wire logic gain_sel,
  input wire logic dout_o,
  input wire logic dout_oe_n,
  input wire logic line
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  logic [31:0] awake_ff;
  logic [5:0]  rise_ff;
  logic        sclk_q_ff;
  wire         sclk_up = sclk && !sclk_q_ff;

  // The rise count wraps at 32 so that it stays aligned to whole words.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      awake_ff  <= 32'h0;
      rise_ff   <= 6'h0;
      sclk_q_ff <= 1'b1;
    end else begin
      sclk_q_ff <= sclk;
      awake_ff  <= !sleep_reset_n ? 32'h0 : awake_ff + {31'h0, ~&awake_ff};
      if (sclk_up) begin
        rise_ff <= (rise_ff == 6'h20) ? 6'h1 : rise_ff + 6'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_last_rise;
    sclk_up && rise_ff == 6'h1f;
  endsequence
  sequence s_low_half;
    (!sclk)[*8];
  endsequence

  property p_float_in_sleep;
    (!sleep_reset_n)[*6] |-> dout_oe_n;
  endproperty
  property p_drive_on_wake;
    $rose(sleep_reset_n) |-> ##[1:8] (!dout_oe_n && dout_o);
  endproperty
  property p_driven_awake;
    sleep_reset_n[*8] |-> !dout_oe_n;
  endproperty
  property p_no_early_word;
    !line |-> awake_ff >= WAKE_CYC + 2 * PER_FAST_CYC;
  endproperty
  property p_word_low_holds;
    $fell(line) && sclk |-> (!line)[*8];
  endproperty
  property p_done_line_high;
    s_last_rise |-> ##[1:8] line ##1 line[*8];
  endproperty
  property p_change_line_high;
    $changed(filter_sel) || $changed(gain_sel) |-> ##7 line[*8];
  endproperty
  property p_pins_still_in_read;
    !sclk |-> $stable(filter_sel) && $stable(gain_sel) && $stable(sleep_reset_n);
  endproperty
  property p_sclk_low_span;
    $fell(sclk) |-> s_low_half ##5 $rose(sclk);
  endproperty

  a_float_in_sleep:     assert property (p_float_in_sleep) else $error("line driven during sleep");
  a_drive_on_wake:      assert property (p_drive_on_wake) else $error("line not high after wake");
  a_driven_awake:       assert property (p_driven_awake) else $error("line floats while awake");
  a_no_early_word:      assert property (p_no_early_word) else $error("word before settling");
  a_word_low_holds:     assert property (p_word_low_holds) else $error("ready dropped early");
  a_done_line_high:     assert property (p_done_line_high) else $error("line not high after word");
  a_change_line_high:   assert property (p_change_line_high) else $error("line low after change");
  a_pins_still_in_read: assert property (p_pins_still_in_read) else $error("pins moved in read");
  a_sclk_low_span:      assert property (p_sclk_low_span) else $error("sclk low phase wrong");
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench: host end driven over APB, device end fed with samples.
// Assumes shortened wake and period counts so the run stays short.
`timescale 1ns/100ps
module tb_top;
  typedef struct packed {logic [31:0] exp; logic [31:0] mask; logic err;} arsr_note_t;
  localparam int unsigned WAKE = 50;
  localparam int unsigned PERF = 3000;
  localparam int unsigned PERS = 4000;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [23:0] sample_data = 24'h0;
  logic        sample_range_err = 1'b0;
  logic [31:0] wire_word = 32'h0;
  logic        sclk_q = 1'b1;
  logic        conv_done;
  int          loads = 0;
  arsr_note_t  note;
  arsr_note_t  notes[$];
  int          errors = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          seed = 64557;

  arsr_if lnk();
  arsr_device #(.WAKE_CYC(WAKE), .PER_FAST_CYC(PERF), .PER_SLOW_CYC(PERS),
    .PART_CODE(arsr_pkg::PART_CODE_DEF)) u_arsr_device (.pclk(pclk), .presetn(presetn),
    .lnk(lnk.device), .sample_data(sample_data), .sample_range_err(sample_range_err), .conv_done(conv_done));
  arsr_host u_arsr_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk.host));
  arsr_asserts #(.WAKE_CYC(WAKE), .PER_FAST_CYC(PERF)) u_arsr_asserts (.pclk(pclk), .presetn(presetn),
    .sclk(lnk.sclk), .sleep_reset_n(lnk.sleep_reset_n), .filter_sel(lnk.filter_sel), .gain_sel(lnk.gain_sel),
    .dout_o(lnk.dout_o), .dout_oe_n(lnk.dout_oe_n), .line(lnk.line));

  always #2.5 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Checks run %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One idle edge at the end keeps back-to-back calls from driving psel twice at once.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  // A zero mask marks a poll whose value is not compared.
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m, input logic er,
                    output logic [31:0] r);
    notes.push_back('{e, m, er});
    apb(1'b0, a, 32'h0, r);
  endtask

  task automatic wait_new(output int t);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < 5000 && r[arsr_pkg::STAT_NEW] !== 1'b1; i++)
      rd(arsr_pkg::REG_STAT, 32'h0, 32'h0, 1'b0, r);
    t = cyc;
  endtask

  // ----------------------------------------------------------------
  // Monitors
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    cyc    <= cyc + 1;
    sclk_q <= lnk.sclk;
    if (conv_done)
      loads <= loads + 1;
    if (lnk.sclk && !sclk_q)
      wire_word <= {wire_word[30:0], lnk.line};
    if (psel && penable && pready && !pwrite && notes.size() != 0) begin
      note = notes.pop_front();
      if (note.mask != 32'h0) begin
        check(prdata & note.mask, note.exp & note.mask);
        check({31'h0, pslverr}, {31'h0, note.err});
      end
    end
  end

  initial begin
    repeat (100000) @(posedge pclk);
    errors++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [31:0] w;
    int          t0;
    int          t1;
    int          t2;
    int          lo;
    logic        f;
    logic        g;
    logic        e;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(arsr_pkg::REG_CTRL, 32'h0, 32'hffffffff, 1'b0, r);
    rd(arsr_pkg::REG_STAT, 32'h0, 32'hf, 1'b0, r);
    wr(12'h00c, 32'hffffffff);
    wr(arsr_pkg::REG_WORD, 32'hffffffff);
    rd(12'h00c, 32'h0, 32'hffffffff, 1'b1, r);
    rd(arsr_pkg::REG_WORD, 32'h0, 32'hffffffff, 1'b0, r);
    check({31'h0, lnk.line_z}, 32'h1);
    // Gray order: gain alone, filter alone, gain alone changes between steps.
    for (int k = 0; k < 4; k++) begin
      f = k[1];
      g = k[0] ^ k[1];
      e = 1'($random(seed));
      sample_data      <= 24'($random(seed));
      sample_range_err <= e;
      @(posedge pclk);
      wr(arsr_pkg::REG_CTRL, {29'h0, g, f, 1'b1});
      t0 = cyc;
      wait_new(t1);
      lo = (k == 0 ? WAKE : 0) + (f ? 3 * PERS : 2 * PERF);
      check({31'h0, (t1 - t0 >= lo) && (t1 - t0 < lo + 1500)}, 32'h1);
      check(loads, (k == 0) ? 1 : k + 2);
      w = {sample_data, 1'b0, f, e, arsr_pkg::PART_CODE_DEF, g, arsr_pkg::CHECK_GOOD};
      rd(arsr_pkg::REG_WORD, w, 32'hffffffff, 1'b0, r);
      check(wire_word, w);
      wr(arsr_pkg::REG_STAT, 32'h1);
      rd(arsr_pkg::REG_STAT, 32'h0, 32'h3, 1'b0, r);
      if (k == 0) begin
        wait_new(t2);
        check({31'h0, (t2 - t1 > PERF - 9) && (t2 - t1 < PERF + 9)}, 32'h1);
        wr(arsr_pkg::REG_STAT, 32'h1);
      end
    end
    wr(arsr_pkg::REG_CTRL, 32'h0);
    repeat (10) @(posedge pclk);
    check({31'h0, lnk.line_z}, 32'h1);
    check({31'h0, lnk.sclk}, 32'h1);
    rd(arsr_pkg::REG_STAT, 32'h0, 32'h8, 1'b0, r);
    wrap_up();
  end
endmodule
